// ### bench/soft_reset_brownout_control_test.sv
// testbench: soft reset and brown-out control over ahb-lite
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end
module soft_reset_brownout_control_test;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic bo_detect = 1'b0;
    logic wdt_reset_event = 1'b0;
    logic hreadyout, hresp, core_rst, pc_load, bo_irq_req, irq;
    logic [31:0] hrdata;
    logic [15:0] pc_value, bo_irq_vector, load_pc;
    logic load_rst;
    logic ce = 1'b1;
    int n_rst = 0;
    int r0 = 0;
    logic [7:0] run = 8'h0;
    logic [7:0] last_run = 8'h0;
    logic [31:0] seed = 32'hb8ec9de3;
    logic [31:0] rd, r;
    int n_mismatch = 0;
    int comparisons = 0;
    int n_load = 0;
    int cyc = 0;
    int n0;

    always #2.5 hclk = ~hclk;

    sbrc_top u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .bo_detect(bo_detect), .wdt_reset_event(wdt_reset_event),
        .core_rst(core_rst), .pc_load(pc_load), .pc_value(pc_value), .bo_irq_req(bo_irq_req),
        .bo_irq_vector(bo_irq_vector), .irq(irq));

    // --------------------------------------------------------------
    // monitor and timeout
    // --------------------------------------------------------------
    // length of each core reset run, and what the pc load carried
    always @(posedge hclk) begin
        cyc++;
        // timeout counts as one mismatch inside the verdict
        if (cyc == 20000) begin
            complete_run(1);
        end
        if (core_rst === 1'b1) begin
            run <= run + 8'h1;
            n_rst <= n_rst + 1;
        end else if (run != 8'h0) begin
            last_run <= run;
            run <= 8'h0;
        end
        if (pc_load === 1'b1) begin
            n_load <= n_load + 1;
            load_pc <= pc_value;
            load_rst <= core_rst;
        end
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // soft reset keeps only the trigger bit of the config register
    function automatic logic [31:0] cfg_after_swr(input logic [31:0] d);
        return d & 32'h2;
    endfunction

    task automatic rnd();
        seed = xs(seed);
        r = seed;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= sbrc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    // bounded wait for the next pc load pulse
    task automatic wait_load(input int lim);
        int i;
        n0 = n_load;
        for (i = 0; i < lim && n_load == n0; i++) @(posedge hclk);
        @(posedge hclk);
        `CHK(n_load, n0 + 1)
        `CHK(load_pc, sbrc_pkg::VEC_RESET)
        `CHK(load_rst, 1'b0)
    endtask

    task automatic complete_run(input int n_to);
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch + n_to);
        if (n_mismatch + n_to == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values and an unmapped place
        chk_rd(sbrc_pkg::ADDR_AUX_IE, 32'h0);
        chk_rd(sbrc_pkg::ADDR_FLASH_CFG, 32'h0);
        chk_rd(sbrc_pkg::ADDR_WDT_CTRL, 32'h0);
        chk_rd(sbrc_pkg::ADDR_IRQ_MASK, 32'h0);
        ahb(1'b1, 8'h20, 32'hff);
        chk_rd(8'h20, 32'h0);
        `CHK({hresp, hreadyout, core_rst, irq}, 4'b0100)
        // random contents, trigger bit left clear
        rnd();
        ahb(1'b1, sbrc_pkg::ADDR_FLASH_CFG, r & 32'hfd);
        chk_rd(sbrc_pkg::ADDR_FLASH_CFG, r & 32'hfd);
        rnd();
        ahb(1'b1, sbrc_pkg::ADDR_AUX_IE, r & 32'hff);
        chk_rd(sbrc_pkg::ADDR_AUX_IE, r & 32'hff);
        rnd();
        ahb(1'b1, sbrc_pkg::ADDR_WDT_CTRL, r & 32'hfb);
        ahb(1'b1, sbrc_pkg::ADDR_IRQ_MASK, 32'h7);
        @(posedge hclk);
        wdt_reset_event <= 1'b1;
        @(posedge hclk);
        wdt_reset_event <= 1'b0;
        ahb(1'b0, sbrc_pkg::ADDR_WDT_CTRL, 32'h0);
        `CHK(rd[sbrc_pkg::BIT_WDT_FLAG], 1'b1)
        `CHK(n_rst, r0)
        // soft reset: trigger 0 to 1
        rnd();
        ahb(1'b1, sbrc_pkg::ADDR_FLASH_CFG, (r & 32'hff) | 32'h2);
        wait_load(20);
        `CHK(last_run, 8'h3)
        chk_rd(sbrc_pkg::ADDR_FLASH_CFG, cfg_after_swr(32'h2));
        chk_rd(sbrc_pkg::ADDR_WDT_CTRL, 32'h1 << sbrc_pkg::BIT_WDT_FLAG);
        chk_rd(sbrc_pkg::ADDR_AUX_IE, 32'h0);
        chk_rd(sbrc_pkg::ADDR_IRQ_MASK, 32'h0);
        `CHK(irq, 1'b0)
        ahb(1'b1, sbrc_pkg::ADDR_IRQ_MASK, 32'h1);
        @(posedge hclk);
        `CHK(irq, 1'b1)
        ahb(1'b0, sbrc_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(rd[sbrc_pkg::EV_SWR], 1'b1)
        chk_rd(sbrc_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(irq, 1'b0)
        // writing 1 over 1 is no trigger; 0 then 1 is
        n0 = n_load;
        ahb(1'b1, sbrc_pkg::ADDR_FLASH_CFG, 32'h2);
        repeat (10) @(posedge hclk);
        `CHK(n_load, n0)
        ahb(1'b1, sbrc_pkg::ADDR_FLASH_CFG, 32'h0);
        ahb(1'b1, sbrc_pkg::ADDR_FLASH_CFG, 32'h2);
        wait_load(20);
        // short brown-out excursions ignored
        r0 = n_rst;
        rnd();
        @(posedge hclk);
        bo_detect <= 1'b1;
        repeat (1 + r % 3) @(posedge hclk);
        bo_detect <= 1'b0;
        repeat (12) @(posedge hclk);
        // ce low freezes the filter, so a long pulse is not taken in
        ce <= 1'b0;
        bo_detect <= 1'b1;
        repeat (8) @(posedge hclk);
        bo_detect <= 1'b0;
        repeat (2) @(posedge hclk);
        ce <= 1'b1;
        repeat (8) @(posedge hclk);
        `CHK(n_rst, r0)
        ahb(1'b0, sbrc_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(rd & 32'h6, 32'h0)
        // default brown-out response: reset held while it lasts
        rnd();
        bo_detect <= 1'b1;
        repeat (10) @(posedge hclk);
        `CHK(core_rst, 1'b1)
        repeat (r % 13) @(posedge hclk);
        `CHK(core_rst, 1'b1)
        bo_detect <= 1'b0;
        wait_load(20);
        ahb(1'b0, sbrc_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(rd[sbrc_pkg::EV_BO_RST], 1'b1)
        // enabled brown-out: interrupt, core keeps running
        ahb(1'b1, sbrc_pkg::ADDR_AUX_IE, 32'h08);
        ahb(1'b1, sbrc_pkg::ADDR_IRQ_MASK, 32'h4);
        r0 = n_rst;
        bo_detect <= 1'b1;
        repeat (12) @(posedge hclk);
        `CHK(n_rst, r0)
        `CHK(bo_irq_req, 1'b1)
        `CHK(bo_irq_vector, 16'h004b)
        `CHK(irq, 1'b1)
        ahb(1'b1, sbrc_pkg::ADDR_IRQ_MASK, 32'h0);
        @(posedge hclk);
        `CHK(irq, 1'b0)
        ahb(1'b0, sbrc_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(rd[sbrc_pkg::EV_BO_IRQ], 1'b1)
        // clearing the enable mid brown-out gives a reset
        ahb(1'b1, sbrc_pkg::ADDR_AUX_IE, 32'h0);
        repeat (3) @(posedge hclk);
        `CHK(core_rst, 1'b1)
        bo_detect <= 1'b0;
        wait_load(20);
        // mid-run bus reset clears the kept trigger bit and the status
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk_rd(sbrc_pkg::ADDR_FLASH_CFG, 32'h0);
        chk_rd(sbrc_pkg::ADDR_IRQ_STAT, 32'h0);
        complete_run(0);
    end
endmodule
`default_nettype wire

// ### verilog/sbrc_bo_filter.sv
// module: brown-out detector glitch filter
`timescale 1ns/1ps
`default_nettype none
module sbrc_bo_filter (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic bo_raw,
    output logic bo_valid
);
    logic sync1_r, sync2_r;
    logic [2:0] cnt_r, cnt_nxt;

    // two-stage sync; the first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else if (ce) begin
            sync1_r <= bo_raw;
            sync2_r <= sync1_r;
        end
    end

    always_comb begin
        cnt_nxt = cnt_r;
        if (!sync2_r) begin
            cnt_nxt = 3'h0;
        end else if (cnt_r != sbrc_pkg::BO_FILTER_CYC) begin
            cnt_nxt = cnt_r + 3'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 3'h0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end

    // valid only after four consecutive asserted samples
    assign bo_valid = (cnt_r == sbrc_pkg::BO_FILTER_CYC);

    AST_BO_FILTER: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(bo_valid) |-> $past(sync2_r, 4) && $past(sync2_r, 1))
        else $error("brown-out accepted before four periods");
endmodule
`default_nettype wire

// ### verilog/sbrc_pkg.sv
// package: constants and carriers for the soft reset / brown-out control block
package sbrc_pkg;
    // ahb register byte addresses
    localparam logic [7:0] ADDR_AUX_IE = 8'he8;
    localparam logic [7:0] ADDR_FLASH_CFG = 8'hec;
    localparam logic [7:0] ADDR_WDT_CTRL = 8'hf0;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'hf4;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hf8;
    localparam logic [7:0] ADDR_STATUS = 8'hfc;
    // field positions
    localparam int BIT_BO_IE = 3;
    localparam int BIT_SWR = 1;
    localparam int BIT_WDT_FLAG = 2;
    localparam int EV_SWR = 0;
    localparam int EV_BO_RST = 1;
    localparam int EV_BO_IRQ = 2;
    // reset values
    localparam logic [7:0] RST_AUX_IE = 8'h00;
    localparam logic [7:0] RST_FLASH_CFG = 8'h00;
    localparam logic [7:0] RST_WDT_CTRL = 8'h00;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;
    // vectors
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_BROWNOUT = 16'h004b;
    // timing: filter length in oscillator periods, reset pulse width less one (core_rst stays high RST_PULSE_CYC + 1 cycles)
    localparam logic [2:0] BO_FILTER_CYC = 3'h4;
    localparam logic [1:0] RST_PULSE_CYC = 2'h2;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [7:0]  addr;
    } sbrc_aphase_s;

    typedef struct packed {
        logic        core_rst;
        logic        pc_load;
        logic [15:0] pc_value;
    } sbrc_ctl_s;

    typedef enum logic [1:0] {
        SBRC_RUN = 2'b00,
        SBRC_RST = 2'b01,
        SBRC_BO_HOLD = 2'b10
    } sbrc_state_e;
endpackage

// ### verilog/sbrc_top.sv
// module: software reset and brown-out control with ahb-lite registers
// Functional notes
// - soft reset on trigger bit rising 0 to 1
// - soft reset loads program counter with 0000H
// - soft reset restores registers to reset values
// - trigger bit, watchdog flag, ram kept
// - enabled brown-out flags interrupt; core keeps running
// - default brown-out response is processor reset
// - brown-out needs four consecutive asserted periods
// - enable is bit 3 at E8H
// - enabled brown-out vectors to 004BH
// - enable cleared during brown-out gives reset
// - disabled brown-out resets to 0000H
`timescale 1ns/1ps
`default_nettype none
module sbrc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic bo_detect,
    input wire logic wdt_reset_event,
    output logic core_rst,
    output logic pc_load,
    output logic [15:0] pc_value,
    output logic bo_irq_req,
    output logic [15:0] bo_irq_vector,
    output logic irq
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    sbrc_pkg::sbrc_aphase_s aph_r, aph_nxt;
    sbrc_pkg::sbrc_state_e st_r, st_nxt;
    sbrc_pkg::sbrc_ctl_s ctl_r, ctl_nxt;
    logic [7:0] aux_ie_r, aux_ie_nxt;
    logic [7:0] flash_cfg_r, flash_cfg_nxt;
    logic [7:0] wdt_ctrl_r, wdt_ctrl_nxt;
    logic [2:0] stat_r, stat_nxt;
    logic [2:0] mask_r, mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] pulse_r, pulse_nxt;
    logic swr_req_r, swr_req_nxt;
    logic bo_irq_r, bo_irq_nxt;
    logic bo_valid;
    logic wr_en, rd_en, swr_rise, bo_ie, soft_rst, bo_rst;
    logic [2:0] ev;

    sbrc_bo_filter u_filter (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .bo_raw(bo_detect),
        .bo_valid(bo_valid)
    );

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction

    // ----------------------------------------------------------------
    // bus decode: zero wait states, always okay
    // ----------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign wr_en = aph_r.sel && aph_r.write;
    assign rd_en = hsel && hready && htrans == sbrc_pkg::HTRANS_NONSEQ && !hwrite;
    assign bo_ie = aux_ie_r[sbrc_pkg::BIT_BO_IE];
    assign swr_rise = wr_en && aph_r.addr == sbrc_pkg::ADDR_FLASH_CFG
        && hwdata[sbrc_pkg::BIT_SWR] && !flash_cfg_r[sbrc_pkg::BIT_SWR];
    // brown-out resets when the enable is off, including when cleared mid-event
    assign bo_rst = bo_valid && !bo_ie;
    assign soft_rst = st_r == sbrc_pkg::SBRC_RST && !swr_req_r ? 1'b0 : (st_r == sbrc_pkg::SBRC_RST);
    assign ev = {bo_valid && bo_ie && !bo_irq_r, bo_rst && st_r == sbrc_pkg::SBRC_RUN,
        swr_rise};

    always_comb begin
        aph_nxt = aph_r;
        rdata_nxt = rdata_r;
        if (hready) begin
            aph_nxt.sel = hsel && htrans == sbrc_pkg::HTRANS_NONSEQ;
            aph_nxt.write = hwrite;
            aph_nxt.addr = haddr[7:0];
        end
        if (rd_en) begin
            case (haddr[7:0])
                sbrc_pkg::ADDR_AUX_IE: rdata_nxt = zext8(aux_ie_r);
                sbrc_pkg::ADDR_FLASH_CFG: rdata_nxt = zext8(flash_cfg_r);
                sbrc_pkg::ADDR_WDT_CTRL: rdata_nxt = zext8(wdt_ctrl_r);
                sbrc_pkg::ADDR_IRQ_STAT: rdata_nxt = {29'h0, stat_r};
                sbrc_pkg::ADDR_IRQ_MASK: rdata_nxt = {29'h0, mask_r};
                sbrc_pkg::ADDR_STATUS: rdata_nxt = {28'h0, bo_irq_r, bo_valid, st_r};
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register file and interrupt status
    // ----------------------------------------------------------------
    always_comb begin
        aux_ie_nxt = aux_ie_r;
        flash_cfg_nxt = flash_cfg_r;
        wdt_ctrl_nxt = wdt_ctrl_r;
        mask_nxt = mask_r;
        stat_nxt = stat_r;
        if (wr_en) begin
            case (aph_r.addr)
                sbrc_pkg::ADDR_AUX_IE: aux_ie_nxt = hwdata[7:0];
                sbrc_pkg::ADDR_FLASH_CFG: flash_cfg_nxt = hwdata[7:0];
                sbrc_pkg::ADDR_WDT_CTRL: wdt_ctrl_nxt = hwdata[7:0];
                sbrc_pkg::ADDR_IRQ_MASK: mask_nxt = hwdata[2:0];
                default: ;
            endcase
        end
        if (rd_en && haddr[7:0] == sbrc_pkg::ADDR_IRQ_STAT) begin
            stat_nxt = 3'h0;
        end
        stat_nxt = stat_nxt | ev; // set wins over read-clear
        if (wdt_reset_event) begin
            wdt_ctrl_nxt[sbrc_pkg::BIT_WDT_FLAG] = 1'b1;
        end
        // soft reset: restore registers except trigger bit, watchdog flag and interrupt status
        if (soft_rst) begin
            aux_ie_nxt = sbrc_pkg::RST_AUX_IE;
            flash_cfg_nxt = sbrc_pkg::RST_FLASH_CFG;
            flash_cfg_nxt[sbrc_pkg::BIT_SWR] = flash_cfg_r[sbrc_pkg::BIT_SWR];
            wdt_ctrl_nxt = sbrc_pkg::RST_WDT_CTRL;
            wdt_ctrl_nxt[sbrc_pkg::BIT_WDT_FLAG] = wdt_ctrl_r[sbrc_pkg::BIT_WDT_FLAG] | wdt_reset_event;
            mask_nxt = sbrc_pkg::RST_IRQ_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_r <= '0;
            rdata_r <= 32'h0;
            aux_ie_r <= sbrc_pkg::RST_AUX_IE;
            flash_cfg_r <= sbrc_pkg::RST_FLASH_CFG;
            wdt_ctrl_r <= sbrc_pkg::RST_WDT_CTRL;
            stat_r <= 3'h0;
            mask_r <= sbrc_pkg::RST_IRQ_MASK;
        end else if (ce) begin
            aph_r <= aph_nxt;
            rdata_r <= rdata_nxt;
            aux_ie_r <= aux_ie_nxt;
            flash_cfg_r <= flash_cfg_nxt;
            wdt_ctrl_r <= wdt_ctrl_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
        end
    end

    assign irq = |(stat_r & mask_r);

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        ctl_nxt = ctl_r;
        pulse_nxt = pulse_r;
        swr_req_nxt = swr_req_r;
        bo_irq_nxt = bo_irq_r;
        ctl_nxt.pc_load = 1'b0;
        // interrupt raised while running; core not held in reset
        if (bo_valid && bo_ie) begin
            bo_irq_nxt = 1'b1;
        end else if (!bo_valid) begin
            bo_irq_nxt = 1'b0;
        end
        case (st_r)
            sbrc_pkg::SBRC_RUN: begin
                // requests come from registered state and the hwdata input, hence synchronous
                if (swr_rise || bo_rst) begin
                    st_nxt = sbrc_pkg::SBRC_RST;
                    swr_req_nxt = swr_rise && !bo_rst;
                    ctl_nxt.core_rst = 1'b1;
                    pulse_nxt = sbrc_pkg::RST_PULSE_CYC;
                end
            end
            sbrc_pkg::SBRC_RST: begin
                swr_req_nxt = 1'b0;
                if (pulse_r != 2'h0) begin
                    pulse_nxt = pulse_r - 2'h1;
                end else if (bo_rst) begin
                    st_nxt = sbrc_pkg::SBRC_BO_HOLD;
                end else begin
                    st_nxt = sbrc_pkg::SBRC_RUN;
                    ctl_nxt.core_rst = 1'b0;
                    ctl_nxt.pc_load = 1'b1;
                    ctl_nxt.pc_value = sbrc_pkg::VEC_RESET;
                end
            end
            sbrc_pkg::SBRC_BO_HOLD: begin
                // hold until supply recovers, then restart at zero
                if (!bo_valid) begin
                    st_nxt = sbrc_pkg::SBRC_RUN;
                    ctl_nxt.core_rst = 1'b0;
                    ctl_nxt.pc_load = 1'b1;
                    ctl_nxt.pc_value = sbrc_pkg::VEC_RESET;
                end
            end
            default: begin
                st_nxt = sbrc_pkg::SBRC_RUN;
                ctl_nxt.core_rst = 1'b0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= sbrc_pkg::SBRC_RUN;
            ctl_r <= '0;
            pulse_r <= 2'h0;
            swr_req_r <= 1'b0;
            bo_irq_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            ctl_r <= ctl_nxt;
            pulse_r <= pulse_nxt;
            swr_req_r <= swr_req_nxt;
            bo_irq_r <= bo_irq_nxt;
        end
    end

    assign core_rst = ctl_r.core_rst;
    assign pc_load = ctl_r.pc_load;
    assign pc_value = ctl_r.pc_value;
    assign bo_irq_req = bo_irq_r;
    assign bo_irq_vector = sbrc_pkg::VEC_BROWNOUT;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_SWR_START: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && swr_rise && st_r == sbrc_pkg::SBRC_RUN |=> core_rst)
        else $error("soft reset trigger did not start reset");
    AST_PC_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        pc_load |-> pc_value == 16'h0000 && $past(core_rst))
        else $error("restart vector not zero");
    AST_RST_WIDTH: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && $rose(core_rst) |-> core_rst ##1 core_rst)
        else $error("reset pulse too short");
    AST_KEEP_SWR: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && soft_rst && !wr_en |=> flash_cfg_r[1] == $past(flash_cfg_r[1]))
        else $error("trigger bit altered by soft reset");
    AST_SFR_RESTORE: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && soft_rst |=> aux_ie_r == 8'h00 && mask_r == 3'h0)
        else $error("registers not restored by soft reset");
    AST_BO_IRQ_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && bo_valid && bo_ie && st_r == sbrc_pkg::SBRC_RUN && !swr_rise |=> bo_irq_req && !core_rst)
        else $error("enabled brown-out did not raise interrupt");
    AST_BO_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && bo_valid && !bo_ie && st_r == sbrc_pkg::SBRC_RUN |=> core_rst)
        else $error("brown-out did not reset core");
    AST_EN_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && bo_valid && $fell(bo_ie) && st_r == sbrc_pkg::SBRC_RUN |=> core_rst)
        else $error("clearing enable during brown-out did not reset");
    AST_VECTOR: assert property (@(posedge hclk) disable iff (!hresetn)
        bo_irq_req |-> bo_irq_vector == 16'h004b)
        else $error("brown-out vector wrong");
    AST_IE_BIT: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && wr_en && aph_r.addr == 8'he8 && !soft_rst |=> bo_ie == $past(hwdata[3]))
        else $error("enable not at bit 3");
    AST_BO_RESTART: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && st_r == sbrc_pkg::SBRC_BO_HOLD && !bo_valid |=> pc_load && !core_rst)
        else $error("no restart after brown-out");

    // ----------------------------------------------------------------
    // checks: sticky status, pulse shape, held states
    // ----------------------------------------------------------------
    AST_STAT_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && ev[sbrc_pkg::EV_BO_IRQ] |=> stat_r[sbrc_pkg::EV_BO_IRQ])
        else $error("brown-out interrupt event lost");
    AST_WDT_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && soft_rst |=> wdt_ctrl_r[sbrc_pkg::BIT_WDT_FLAG]
            == ($past(wdt_ctrl_r[sbrc_pkg::BIT_WDT_FLAG]) | $past(wdt_reset_event)))
        else $error("watchdog flag altered by soft reset");
    AST_PC_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && pc_load |=> !pc_load)
        else $error("pc load longer than one cycle");
    AST_RUN_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && st_r == sbrc_pkg::SBRC_RUN && !swr_rise && !bo_rst |=> !core_rst)
        else $error("core reset without a request");
    AST_HOLD_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && st_r == sbrc_pkg::SBRC_BO_HOLD && bo_valid |=> core_rst && !pc_load)
        else $error("core released during brown-out");
    AST_SWR_ONE_OVER_ONE: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && wr_en && aph_r.addr == sbrc_pkg::ADDR_FLASH_CFG && flash_cfg_r[sbrc_pkg::BIT_SWR]
            && st_r == sbrc_pkg::SBRC_RUN && !bo_rst |=> !core_rst)
        else $error("soft reset without a change from zero");
endmodule
`default_nettype wire
